//--- logic/tcr_control.sv
// control register, data holding, baud timer and input filters of the two-wire controller
// ----------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------
// Summary of operation
// - control bit 7 switches the shift engine on or off; filters and the bit 4 timer still run while off
// - request bits take a written 1 only while enabled; a written 0 is ignored
// - start bit 6 makes master send start, then clears; disable clears it
// - start goes out only once a byte is held in data or shift register
// - start during a byte shift becomes a restart after byte and acknowledge
// - with start and stop both pending, stop goes first, then start
// - start written during a slave transaction clears and sets arbitration lost
// - stop bit 5 makes master stop after current byte sent or received
// - stop clears after the stop condition is sent, or on disable
// - stop set during a slave transaction is cleared by hardware
// - baud timer request bit 4 has no effect while enabled
// - disabled with bit 4 set, baud generator runs free, pulsing at count one
// - bit 3 gates the empty data register onto the interrupt request
// - bit 2 makes the next received byte answered with not-acknowledge
// - not-acknowledge request clears once sent, or on disable
// - writing 1 to bit 1 empties data register and sets the empty flag
// - flush bit is write only and reads as zero
// - bit 0 filters sda and scl, rejecting pulses under two clocks
// - enabled filters delay sda and scl by exactly four clocks
// - arbitration lost flag clears when the status register is read
// - empty flag clears when software writes a new data byte
`default_nettype none
module tcr_control #(
  parameter int FILT_LAT = tcr_pkg::TCR_FILT_LAT
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [tcr_pkg::TCR_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // bus pins, input side
  input  wire logic                          sda_in,
  input  wire logic                          scl_in,
  output logic                               sda_filt,
  output logic                               scl_filt,
  // shift engine status
  input  wire logic                          eng_master,
  input  wire logic                          eng_slave_busy,
  input  wire logic                          eng_byte_busy,
  input  wire logic                          eng_shift_full,
  input  wire logic                          eng_byte_take,
  input  wire logic                          eng_start_done,
  input  wire logic                          eng_stop_done,
  input  wire logic                          eng_nak_done,
  input  wire logic                          eng_arb_lost,
  // requests to the shift engine
  output logic                               controller_enable,
  output logic                               start_go,
  output logic                               stop_go,
  output logic                               nak_request,
  output logic      [7:0]                    twi_data_byte,
  output logic                               tx_holding_empty_flag,
  output logic                               baud_tick,
  output logic      [15:0]                   baud_count,
  output logic                               irq_request
);
  import tcr_pkg::*;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [TCR_ADDR_W-1:0] a, input logic [11:0] idx);
    hit = (a == {2'b00, idx, 2'b00});
  endfunction : hit

  logic acc;
  logic hit_data;
  logic hit_stat;
  logic hit_ctrl;
  logic hit_brh;
  logic hit_brl;
  logic mapped;
  logic wr_data;
  logic wr_ctrl;
  logic rd_stat;

  assign acc      = psel && penable;
  assign hit_data = hit(paddr, TCR_IDX_DATA);
  assign hit_stat = hit(paddr, TCR_IDX_STATUS);
  assign hit_ctrl = hit(paddr, TCR_IDX_CTRL);
  assign hit_brh  = hit(paddr, TCR_IDX_BRH);
  assign hit_brl  = hit(paddr, TCR_IDX_BRL);
  assign mapped   = hit_data || hit_stat || hit_ctrl || hit_brh || hit_brl;
  assign wr_data  = acc && pwrite && hit_data;
  assign wr_ctrl  = acc && pwrite && hit_ctrl;
  assign rd_stat  = acc && !pwrite && hit_stat;
  // zero wait states; unmapped access errors and writes nothing
  assign pready   = 1'b1;
  assign pslverr  = acc && !mapped;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic en_q;
  logic start_q;
  logic stop_q;
  logic baud_timer_irq_request_q;
  logic txi_q;
  logic nak_q;
  logic filt_q;
  logic arb_q;
  logic tx_holding_empty_flag_q;
  logic [7:0] data_q;
  logic [15:0] brg_q;
  logic start_set;
  logic start_clash;
  logic flush;

  // a set needs the enable already on, so one write cannot enable and request
  assign start_set   = wr_ctrl && pwdata[TCR_CTL_START] && en_q;
  assign start_clash = start_set && eng_slave_busy;
  assign flush       = wr_ctrl && pwdata[TCR_CTL_FLUSH];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      en_q   <= TCR_CTRL_RST[TCR_CTL_EN];
      baud_timer_irq_request_q <= TCR_CTRL_RST[TCR_CTL_BAUD_TIMER_IRQ_REQUEST];
      txi_q  <= TCR_CTRL_RST[TCR_CTL_TXI];
      filt_q <= TCR_CTRL_RST[TCR_CTL_FILT];
    end else if (wr_ctrl) begin
      en_q   <= pwdata[TCR_CTL_EN];
      baud_timer_irq_request_q <= pwdata[TCR_CTL_BAUD_TIMER_IRQ_REQUEST];
      txi_q  <= pwdata[TCR_CTL_TXI];
      filt_q <= pwdata[TCR_CTL_FILT];
    end
  end

  // a new request wins over the engine's done pulse in the same cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      start_q <= TCR_CTRL_RST[TCR_CTL_START];
    end else if (!en_q || start_clash) begin
      start_q <= 1'b0;
    end else if (start_set) begin
      start_q <= 1'b1;
    end else if (eng_start_done) begin
      start_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stop_q <= TCR_CTRL_RST[TCR_CTL_STOP];
    end else if (!en_q || eng_slave_busy) begin
      stop_q <= 1'b0;
    end else if (wr_ctrl && pwdata[TCR_CTL_STOP]) begin
      stop_q <= 1'b1;
    end else if (eng_stop_done) begin
      stop_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      nak_q <= TCR_CTRL_RST[TCR_CTL_NAK];
    end else if (!en_q) begin
      nak_q <= 1'b0;
    end else if (wr_ctrl && pwdata[TCR_CTL_NAK]) begin
      nak_q <= 1'b1;
    end else if (eng_nak_done) begin
      nak_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status flags and data holding register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      arb_q <= 1'b0;
    end else if (eng_arb_lost || start_clash) begin
      arb_q <= 1'b1;
    end else if (rd_stat) begin
      arb_q <= 1'b0;
    end
  end

  // a data write in the take cycle holds a fresh byte, so it leaves the flag low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_holding_empty_flag_q <= TCR_TX_HOLDING_EMPTY_FLAG_RST;
      data_q <= TCR_DATA_RST;
    end else if (flush) begin
      tx_holding_empty_flag_q <= 1'b1;
      data_q <= TCR_DATA_RST;
    end else if (wr_data) begin
      tx_holding_empty_flag_q <= 1'b0;
      data_q <= pwdata[7:0];
    end else if (eng_byte_take) begin
      tx_holding_empty_flag_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      brg_q <= TCR_BRG_RST;
    end else if (acc && pwrite && hit_brh) begin
      brg_q <= {pwdata[7:0], brg_q[7:0]};
    end else if (acc && pwrite && hit_brl) begin
      brg_q <= {brg_q[15:8], pwdata[7:0]};
    end
  end

  // ----------------------------------------------------------------
  // requests to the engine
  // ----------------------------------------------------------------
  logic byte_held;
  assign byte_held = !tx_holding_empty_flag_q || eng_shift_full;
  // stop drains first; a start waits for the byte and its acknowledge
  assign start_go    = start_q && eng_master && byte_held
                       && !stop_q && !eng_byte_busy;
  assign stop_go     = stop_q && eng_master && !eng_byte_busy;
  assign nak_request = nak_q;
  assign controller_enable     = en_q;
  assign twi_data_byte         = data_q;
  assign tx_holding_empty_flag = tx_holding_empty_flag_q;

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  tcr_baud_e mode;
  logic [15:0] cnt_q;
  logic tick_q;

  always_comb begin
    case ({en_q, baud_timer_irq_request_q})
      2'b10, 2'b11: mode = TCR_BAUD_LINK;
      2'b01:        mode = TCR_BAUD_TIMER;
      default:      mode = TCR_BAUD_IDLE;
    endcase
  end

  // a reload of zero counts the full 65536 states
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q  <= TCR_BRG_RST;
      tick_q <= 1'b0;
    end else if (mode == TCR_BAUD_IDLE) begin
      cnt_q  <= brg_q;
      tick_q <= 1'b0;
    end else if (cnt_q == 16'h0001) begin
      cnt_q  <= brg_q;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q - 16'h0001;
      tick_q <= 1'b0;
    end
  end

  assign baud_tick  = tick_q;
  assign baud_count = cnt_q;
  assign irq_request = (txi_q && tx_holding_empty_flag_q && en_q)
                       || (tick_q && mode == TCR_BAUD_TIMER)
                       || arb_q;

  // ----------------------------------------------------------------
  // input synchronisers and spike filters
  // ----------------------------------------------------------------
  logic [1:0] pin_in;
  logic [1:0] pin_out;
  assign pin_in   = {scl_in, sda_in};
  assign sda_filt = pin_out[0];
  assign scl_filt = pin_out[1];

  for (genvar g = 0; g < 2; g++) begin : g_filt
    logic [FILT_LAT-1:0] sh_q;
    logic                out_q;
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        sh_q <= '1;
      end else begin
        sh_q <= {sh_q[FILT_LAT-2:0], pin_in[g]};
      end
    end
    // filtered path takes a level only once the last two stages agree
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        out_q <= 1'b1;
      end else if (!filt_q) begin
        out_q <= sh_q[FILT_LAT-1];
      end else if (sh_q[FILT_LAT-1] == sh_q[FILT_LAT-2]) begin
        out_q <= sh_q[FILT_LAT-1];
      end
    end
    assign pin_out[g] = out_q;
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [7:0] ctrl_rd;
  logic [7:0] stat_rd;
  assign ctrl_rd = {en_q, start_q, stop_q, baud_timer_irq_request_q, txi_q, nak_q, 1'b0, filt_q};
  assign stat_rd = {tx_holding_empty_flag_q, 4'h0, arb_q, 2'h0};

  always_comb begin
    prdata = 32'h0000_0000;
    if (acc && !pwrite) begin
      if (hit_data) prdata[7:0] = data_q;
      if (hit_stat) prdata[7:0] = stat_rd;
      if (hit_ctrl) prdata[7:0] = ctrl_rd;
      if (hit_brh)  prdata[7:0] = brg_q[15:8];
      if (hit_brl)  prdata[7:0] = brg_q[7:0];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_disable;
    wr_ctrl && !pwdata[TCR_CTL_EN];
  endsequence
  sequence s_requests_gone;
    !start_q && !stop_q && !nak_q;
  endsequence

  AST_EN_FOLLOWS: assert property (wr_ctrl |=> en_q == $past(pwdata[TCR_CTL_EN]))
    else $error("enable does not follow write");
  AST_ZERO_NO_CLEAR: assert property (start_q && en_q && wr_ctrl && !pwdata[TCR_CTL_START]
      && pwdata[TCR_CTL_EN] && !eng_start_done && !eng_slave_busy |=> start_q)
    else $error("start cleared by written zero");
  AST_DISABLE_CLEARS: assert property (s_disable |=> ##1 s_requests_gone)
    else $error("requests survive disable");
  AST_START_NEEDS_BYTE: assert property (start_go |-> byte_held && !eng_byte_busy)
    else $error("start without byte");
  AST_STOP_FIRST: assert property (stop_q |-> !start_go)
    else $error("start before pending stop");
  AST_SLAVE_CLASH: assert property (start_clash |=> !start_q && arb_q)
    else $error("slave clash not handled");
  AST_STOP_SLAVE: assert property (eng_slave_busy |=> !stop_q)
    else $error("stop kept during slave");
  AST_TIMER_TICK: assert property (mode == TCR_BAUD_TIMER && cnt_q == 16'h0001
      |=> irq_request && cnt_q == $past(brg_q))
    else $error("timer tick missing");
  AST_FLUSH: assert property (flush |=> tx_holding_empty_flag_q && data_q == TCR_DATA_RST)
    else $error("flush failed");
  AST_ARB_READ: assert property (rd_stat && !eng_arb_lost && !start_clash |=> !arb_q)
    else $error("arbitration flag not cleared");
  AST_TX_HOLDING_EMPTY_FLAG_WRITE: assert property (wr_data && !flush |=> !tx_holding_empty_flag_q)
    else $error("empty flag not cleared");
endmodule : tcr_control
`default_nettype wire

//--- include/tcr_pkg.sv
// constants shared by the two-wire control register block
`default_nettype none
package tcr_pkg;
  // register indices; the byte address is four times the index
  localparam logic [11:0] TCR_IDX_DATA   = 12'hF50;
  localparam logic [11:0] TCR_IDX_STATUS = 12'hF51;
  localparam logic [11:0] TCR_IDX_CTRL   = 12'hF52;
  localparam logic [11:0] TCR_IDX_BRH    = 12'hF53;
  localparam logic [11:0] TCR_IDX_BRL    = 12'hF54;
  localparam int TCR_ADDR_W = 16;
  // control field positions
  localparam int TCR_CTL_EN    = 7;
  localparam int TCR_CTL_START = 6;
  localparam int TCR_CTL_STOP  = 5;
  localparam int TCR_CTL_BAUD_TIMER_IRQ_REQUEST  = 4;
  localparam int TCR_CTL_TXI   = 3;
  localparam int TCR_CTL_NAK   = 2;
  localparam int TCR_CTL_FLUSH = 1;
  localparam int TCR_CTL_FILT  = 0;
  // status field positions
  localparam int TCR_ST_TX_HOLDING_EMPTY_FLAG   = 7;
  localparam int TCR_ST_ARBITRATION_LOST_FLAG = 2;
  // reset values
  localparam logic [7:0]  TCR_CTRL_RST = 8'h00;
  localparam logic [7:0]  TCR_DATA_RST = 8'h00;
  localparam logic [15:0] TCR_BRG_RST  = 16'hFFFF;
  localparam logic        TCR_TX_HOLDING_EMPTY_FLAG_RST = 1'b1;
  // spike filter shift stages; the filtered pins lag one system clock more
  localparam int TCR_FILT_LAT = 3;
  // mode of the baud generator
  typedef enum logic [1:0] {TCR_BAUD_IDLE, TCR_BAUD_LINK, TCR_BAUD_TIMER} tcr_baud_e;
endpackage : tcr_pkg
`default_nettype wire

//--- tb/tcr_engine_model.sv
// behavioural shift engine answering start, stop and not-acknowledge requests
`default_nettype none
module tcr_engine_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // requests and answer delay
  input  wire logic       start_go,
  input  wire logic       stop_go,
  input  wire logic       nak_request,
  input  wire logic [3:0] dly,
  // condition sent pulses
  output logic            eng_start_done,
  output logic            eng_stop_done,
  output logic            eng_nak_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_q;
  // ----------------------------------------------------------------
  // condition timing
  // ----------------------------------------------------------------
  // the count stands for bus time of one condition; start and stop get no priority here, so the order of
  // start and stop is left entirely to the block under test
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q          <= 5'h00;
      eng_start_done <= 1'b0;
      eng_stop_done  <= 1'b0;
      eng_nak_done   <= 1'b0;
    end else begin
      eng_stop_done  <= (cnt_q == 5'h01) && stop_go;
      eng_start_done <= (cnt_q == 5'h01) && start_go;
      eng_nak_done   <= (cnt_q == 5'h01) && !stop_go && !start_go && nak_request;
      if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q - 5'h01;
      end else if (stop_go || start_go || nak_request) begin
        cnt_q <= {1'b0, dly} + 5'h01;
      end
    end
  end
endmodule : tcr_engine_model
`default_nettype wire

//--- tb/tb_i2c_control_register_logic.sv
// self-checking bench for the two-wire control register block
`default_nettype none
module tb_i2c_control_register_logic;
  timeunit 1ns;
  timeprecision 1ps;
  import tcr_pkg::*;
  typedef struct packed {logic [7:0] wr; logic [7:0] rd;} tcr_row_s;
  localparam logic [15:0] A_DATA = {2'b00, TCR_IDX_DATA, 2'b00};
  localparam logic [15:0] A_STAT = {2'b00, TCR_IDX_STATUS, 2'b00};
  localparam logic [15:0] A_CTRL = {2'b00, TCR_IDX_CTRL, 2'b00};
  localparam logic [15:0] A_BRH  = {2'b00, TCR_IDX_BRH, 2'b00};
  localparam logic [15:0] A_BRL  = {2'b00, TCR_IDX_BRL, 2'b00};
  localparam tcr_row_s    ROWS [0:6] = '{'{8'h19, 8'h19}, '{8'h1B, 8'h19}, '{8'h64, 8'h00},
    '{8'h80, 8'h80}, '{8'h84, 8'h84}, '{8'h80, 8'h84}, '{8'h00, 8'h00}};
  logic        clk_sys, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [15:0] paddr, baud_count;
  logic [31:0] pwdata, prdata, rd;
  logic        sda_in, scl_in, sda_filt, scl_filt, eng_master, eng_slave_busy;
  logic        eng_byte_busy, eng_shift_full, eng_byte_take, eng_arb_lost;
  logic        eng_start_done, eng_stop_done, eng_nak_done, controller_enable;
  logic        start_go, stop_go, nak_request, tx_holding_empty_flag, baud_tick;
  logic        irq_request;
  logic [7:0]  twi_data_byte;
  logic [3:0]  dly;
  logic [1:0]  first_q;
  logic        first_clr;
  int          fails, comparisons, n;

  tcr_control i_dut (
    .clk_sys               (clk_sys),
    .nrst                  (nrst),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .sda_in                (sda_in),
    .scl_in                (scl_in),
    .sda_filt              (sda_filt),
    .scl_filt              (scl_filt),
    .eng_master            (eng_master),
    .eng_slave_busy        (eng_slave_busy),
    .eng_byte_busy         (eng_byte_busy),
    .eng_shift_full        (eng_shift_full),
    .eng_byte_take         (eng_byte_take),
    .eng_start_done        (eng_start_done),
    .eng_stop_done         (eng_stop_done),
    .eng_nak_done          (eng_nak_done),
    .eng_arb_lost          (eng_arb_lost),
    .controller_enable     (controller_enable),
    .start_go              (start_go),
    .stop_go               (stop_go),
    .nak_request           (nak_request),
    .twi_data_byte         (twi_data_byte),
    .tx_holding_empty_flag (tx_holding_empty_flag),
    .baud_tick             (baud_tick),
    .baud_count            (baud_count),
    .irq_request           (irq_request)
  );
  tcr_engine_model i_eng (
    .clk_sys        (clk_sys),
    .nrst           (nrst),
    .start_go       (start_go),
    .stop_go        (stop_go),
    .nak_request    (nak_request),
    .dly            (dly),
    .eng_start_done (eng_start_done),
    .eng_stop_done  (eng_stop_done),
    .eng_nak_done   (eng_nak_done)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // which condition the engine reported first since the last clear; both at once gives 3
  always @(posedge clk_sys) begin
    if (!nrst || first_clr) begin
      first_q <= 2'd0;
    end else if (first_q == 2'd0) begin
      first_q <= {eng_start_done === 1'b1, eng_stop_done === 1'b1};
    end
  end
  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {31'd0, e}, {31'd0, g});
  endtask : chk1
  task automatic limit(input string nm, input logic ok);
    if (!ok) begin
      chk(nm, 32'd1, 32'd0);
      results();
    end
  endtask : limit
  // master holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    limit("pready wait", pready === 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [15:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdc
  task automatic poll(input logic [31:0] e);
    int k = 0;
    do begin
      apb(1'b0, A_CTRL, 32'h0);
      k++;
    end while (rd !== e && k < 30);
    chk("control settle", e, rd);
  endtask : poll
  task automatic wait_tick(input int lim);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (baud_tick !== 1'b1 && n < lim);
    limit("timer tick wait", baud_tick === 1'b1);
  endtask : wait_tick
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {eng_master, eng_slave_busy, eng_byte_busy, eng_shift_full} = '0;
    {eng_byte_take, eng_arb_lost, first_clr, fails, comparisons} = '0;
    sda_in = 1'b1;
    scl_in = 1'b1;
    dly    = 4'hF;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rdc(A_CTRL, 32'h00, "control reset");
    rdc(A_STAT, 32'h80, "status reset");
    apb(1'b0, 16'h3D60, 32'h0);
    chk1("unmapped error", 1'b1, err);
    $display("test reset done");
    foreach (ROWS[i]) begin
      wr(A_CTRL, {24'h0, ROWS[i].wr});
      rdc(A_CTRL, {24'h0, ROWS[i].rd}, "control row");
    end
    $display("test rows done");
    dly <= 4'h2;
    wr(A_CTRL, 32'h80);
    wr(A_DATA, 32'h5A);
    chk("data byte out", 32'h5A, {24'h0, twi_data_byte});
    chk1("empty flag out", 1'b0, tx_holding_empty_flag);
    chk1("enable out", 1'b1, controller_enable);
    rdc(A_STAT, 32'h00, "status after data");
    wr(A_CTRL, 32'h80);
    rdc(A_DATA, 32'h5A, "data kept");
    wr(A_CTRL, 32'h82);
    rdc(A_STAT, 32'h80, "status after flush");
    rdc(A_DATA, 32'h00, "data after flush");
    wr(A_CTRL, 32'h84);
    chk1("nak out", 1'b1, nak_request);
    poll(32'h80);
    $display("test flush done");
    eng_master <= 1'b1;
    wr(A_CTRL, 32'hC0);
    repeat (20) @(posedge clk_sys);
    rdc(A_CTRL, 32'hC0, "start waits for byte");
    chk1("start go held", 1'b0, start_go);
    wr(A_CTRL, 32'h80);
    rdc(A_CTRL, 32'hC0, "start kept by zero");
    wr(A_DATA, 32'h33);
    poll(32'h80);
    eng_byte_take <= 1'b1;
    @(posedge clk_sys);
    eng_byte_take <= 1'b0;
    rdc(A_STAT, 32'h80, "status after take");
    wr(A_DATA, 32'h44);
    first_clr <= 1'b1;
    @(posedge clk_sys);
    first_clr <= 1'b0;
    wr(A_CTRL, 32'hE0);
    poll(32'h80);
    chk("first condition", 32'd1, {30'd0, first_q});
    eng_byte_busy <= 1'b1;
    wr(A_CTRL, 32'hC0);
    repeat (10) @(posedge clk_sys);
    rdc(A_CTRL, 32'hC0, "restart held");
    chk1("restart go held", 1'b0, start_go);
    eng_byte_busy <= 1'b0;
    poll(32'h80);
    $display("test start stop done");
    eng_master     <= 1'b0;
    eng_slave_busy <= 1'b1;
    wr(A_CTRL, 32'hA0);
    rdc(A_CTRL, 32'h80, "stop in slave");
    wr(A_CTRL, 32'hC0);
    rdc(A_CTRL, 32'h80, "start in slave");
    apb(1'b0, A_STAT, 32'h0);
    chk1("arbitration set", 1'b1, rd[TCR_ST_ARBITRATION_LOST_FLAG]);
    apb(1'b0, A_STAT, 32'h0);
    chk1("arbitration cleared", 1'b0, rd[TCR_ST_ARBITRATION_LOST_FLAG]);
    eng_slave_busy <= 1'b0;
    $display("test slave done");
    wr(A_CTRL, 32'h82);
    wr(A_CTRL, 32'h88);
    chk1("empty irq on", 1'b1, irq_request);
    wr(A_CTRL, 32'h80);
    chk1("empty irq off", 1'b0, irq_request);
    // idle mode reloads the counter every cycle, so the timer starts from the new value
    wr(A_CTRL, 32'h00);
    wr(A_BRH, 32'h00);
    wr(A_BRL, 32'h05);
    @(posedge clk_sys);
    chk("baud count load", 32'h5, {16'h0, baud_count});
    wr(A_CTRL, 32'h10);
    wait_tick(70000);
    chk1("timer irq", 1'b1, irq_request);
    wait_tick(20);
    chk("timer period", 32'd5, n);
    wr(A_CTRL, 32'h90);
    n = 0;
    repeat (20) begin
      @(posedge clk_sys);
      if (irq_request !== 1'b0) n++;
    end
    chk("irq while enabled", 32'd0, n);
    $display("test timer done");
    wr(A_CTRL, 32'h81);
    sda_in <= 1'b0;
    n = 0;
    // look at the settled output half a period after each edge
    do begin
      @(posedge clk_sys);
      n++;
      @(negedge clk_sys);
    end while (sda_filt !== 1'b0 && n < 10);
    chk("filter latency", TCR_FILT_LAT + 1, n);
    @(posedge clk_sys);
    scl_in <= 1'b0;
    @(posedge clk_sys);
    scl_in <= 1'b1;
    n = 0;
    repeat (8) begin
      @(posedge clk_sys);
      if (scl_filt !== 1'b1) n++;
    end
    chk("glitch passed", 32'd0, n);
    $display("test filter done");
    results();
  end
endmodule : tb_i2c_control_register_logic
`default_nettype wire
